// File: rtl/can_filt_pkg.sv
// constants and types for the acceptance filter control and queue status block
package can_filt_pkg;
	localparam int ADDR_W = 12;
	// register byte addresses
	localparam logic [ADDR_W-1:0] OFS_FILTER_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_QUEUE_DIR   = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR   = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE  = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_QUEUE_FLAGS = 12'h080;
	// field positions inside one filter byte
	localparam int FLT_ON_BIT   = 7;
	localparam int FLT_MASK_LSB = 5;
	localparam int FLT_DEST_LSB = 0;
	// queue flag bit positions
	localparam int TX_HALF_BIT  = 9;
	localparam int TX_EMPTY_BIT = 8;
	localparam int RX_OVFL_BIT  = 3;
	localparam int RX_FULL_BIT  = 2;
	localparam int RX_HALF_BIT  = 1;
	localparam int RX_NEMP_BIT  = 0;
	// reset values
	localparam logic [31:0] RST_FILTER_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

	// one filter's settings
	typedef struct packed {
		logic       on;
		logic [1:0] mask_choice;
		logic [4:0] dest_queue;
	} filter_cfg_t;
endpackage : can_filt_pkg

// File: rtl/can_filter_fifo_status.sv
// apb register block: filter control word, per-queue status flags and interrupt
`timescale 1ns/100ps
`default_nettype none
module can_filter_fifo_status
	import can_filt_pkg::*;
#(
	parameter int NQ     = 32,
	parameter int DEPTH  = 8,
	parameter int CNT_W  = 4
)(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	input  wire logic [NQ-1:0]        push,
	input  wire logic [NQ-1:0]        pop,
	output filter_cfg_t [3:0]         filter_cfg,
	output logic [NQ-1:0]             queue_is_transmit,
	output logic                      irq
);
	logic [31:0]          filter_ctrl;
	logic [NQ-1:0]        rx_ovfl;
	logic [NQ-1:0]        irq_en;
	logic [CNT_W-1:0]     occ [NQ];
	logic [NQ-1:0]        full_v;
	logic [NQ-1:0]        ev_any;
	logic [NQ-1:0]        flagvec;
	logic                 wr;
	logic                 rd;
	logic [31:0]          next_rdata;
	logic                 addr_ok;
	logic [4:0]           qsel;
	logic                 flag_rd;

	localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] HALF_C  = CNT_W'(DEPTH / 2);

	// register map in byte addresses:
	//   filter control word: four filters, one byte each, highest filter in the top byte
	//   direction word: one bit per queue, set means the queue transmits
	//   overflow status word: one sticky bit per queue, read-only
	//   overflow clear word: write ones to clear status bits, reads zero
	//   interrupt enable word: same layout as the status word
	//   flag words: one per queue, four bytes apart, from the flag base upward
	// bus timing:
	//   the slave never stretches a transfer; pready rises in the first access cycle
	//   read data is captured at the setup edge and stands until the next read
	//   an unmapped address answers with pslverr, reads zero and drops the write
	// filter locking:
	//   a byte whose enable bit is set keeps its mask and queue fields
	//   the enable bit itself stays writable, else software could never unlock it
	//   software is expected to clear the enable before it rewrites the fields
	// queue flags:
	//   level flags are decoded live from the occupancy counter on every read
	//   the side that does not match the direction bit always reads zero
	//   only the overflow flag is latched; it survives a later drain of the queue
	//   a push into a full queue is dropped, and counts as overflow only on receive
	// limitations:
	//   occupancy is counted here, message storage lives elsewhere
	//   a pop on an empty queue is ignored rather than flagged
	//   the interrupt follows status and enable with one cycle of lag
	//   changing a queue's direction does not clear its overflow bit
	//   the counter width must hold the depth itself, not only depth minus one
	//   half is the depth divided by two, rounded down for odd depths

	// access is taken on the access phase; one wait-free cycle
	assign wr   = psel & penable & pwrite;
	assign rd   = psel & penable & ~pwrite;
	assign qsel = paddr[6:2];
	// setup phase of a read aimed at any queue's flag word
	assign flag_rd = psel & ~penable & ~pwrite & (paddr[1:0] == 2'b00)
		& (paddr[ADDR_W-1:7] == OFS_QUEUE_FLAGS[ADDR_W-1:7]);

	// filter control word: a byte only takes new mask and queue bits while its enable is zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			filter_ctrl <= RST_FILTER_CTRL;
		else if (wr && paddr == OFS_FILTER_CTRL)
		begin
			for (int b = 0; b < 4; b++)
				if (pstrb[b] && !filter_ctrl[8*b + FLT_ON_BIT])
					filter_ctrl[8*b +: 8] <= pwdata[8*b +: 8];
				else if (pstrb[b])
					// enabled filter: only the enable bit itself may drop
					filter_ctrl[8*b + FLT_ON_BIT] <= pwdata[8*b + FLT_ON_BIT];
		end
	end

	// decode bytes into per-filter settings for the matching logic
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			filter_cfg <= '0;
		else
			for (int b = 0; b < 4; b++)
			begin
				filter_cfg[b].on          <= filter_ctrl[8*b + FLT_ON_BIT];
				filter_cfg[b].mask_choice <= filter_ctrl[8*b + FLT_MASK_LSB +: 2];
				filter_cfg[b].dest_queue  <= filter_ctrl[8*b + FLT_DEST_LSB +: 5];
			end
	end

	// direction bits per queue
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			queue_is_transmit <= RST_ZERO[NQ-1:0];
		else if (wr && paddr == OFS_QUEUE_DIR)
			queue_is_transmit <= pwdata[NQ-1:0];
	end

	// occupancy counters; a push into a full queue is dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int q = 0; q < NQ; q++)
				occ[q] <= '0;
		else
			for (int q = 0; q < NQ; q++)
			begin
				if ((push[q] && !full_v[q]) && !(pop[q] && occ[q] != '0))
					occ[q] <= occ[q] + CNT_W'(1);
				else if (!(push[q] && !full_v[q]) && pop[q] && occ[q] != '0)
					occ[q] <= occ[q] - CNT_W'(1);
			end
	end

	always_comb
	begin
		for (int q = 0; q < NQ; q++)
			full_v[q] = (occ[q] == DEPTH_C);
	end

	// sticky overflow: set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_ovfl <= '0;
		else
			for (int q = 0; q < NQ; q++)
				if (!queue_is_transmit[q] && push[q] && full_v[q])
					rx_ovfl[q] <= 1'b1;
				else if (wr && paddr == OFS_IRQ_CLEAR && pwdata[q])
					rx_ovfl[q] <= 1'b0;
	end

	// interrupt enable register, one bit per queue
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_en <= RST_ZERO[NQ-1:0];
		else if (wr && paddr == OFS_IRQ_ENABLE)
			irq_en <= pwdata[NQ-1:0];
	end

	always_comb
	begin
		ev_any = rx_ovfl & irq_en;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |ev_any;
	end

	// live flag word for the addressed queue; direction masks the other side
	always_comb
	begin
		flagvec = '0;
		next_rdata = UNMAPPED_DATA;
		addr_ok = 1'b1;
		if (paddr[ADDR_W-1:7] == OFS_QUEUE_FLAGS[ADDR_W-1:7] && paddr[1:0] == 2'b00)
		begin
			if (queue_is_transmit[qsel])
			begin
				next_rdata[TX_HALF_BIT]  = (occ[qsel] <= HALF_C);
				next_rdata[TX_EMPTY_BIT] = (occ[qsel] == '0);
			end
			else
			begin
				next_rdata[RX_OVFL_BIT]  = rx_ovfl[qsel];
				next_rdata[RX_FULL_BIT]  = full_v[qsel];
				next_rdata[RX_HALF_BIT]  = (occ[qsel] >= HALF_C);
				next_rdata[RX_NEMP_BIT]  = (occ[qsel] != '0);
			end
		end
		else
			unique case (paddr)
				OFS_FILTER_CTRL: next_rdata = filter_ctrl;
				OFS_QUEUE_DIR:   next_rdata[NQ-1:0] = queue_is_transmit;
				OFS_IRQ_STATUS:  next_rdata[NQ-1:0] = rx_ovfl;
				OFS_IRQ_CLEAR:   next_rdata = RST_ZERO;
				OFS_IRQ_ENABLE:  next_rdata[NQ-1:0] = irq_en;
				default:         addr_ok = 1'b0;
			endcase
		flagvec[0] = addr_ok;
	end

	// bus answer: data and error registered, pready raised in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~flagvec[0];
			if (psel && !penable && !pwrite)
				prdata <= next_rdata;
		end
	end

	// filter byte held while enabled
	a_cfg_locked: assert property (@(posedge pclk) disable iff (!presetn)
		filter_ctrl[31] && $past(filter_ctrl[31]) |-> filter_ctrl[30:24] == $past(filter_ctrl[30:24]))
		else $error("enabled filter settings changed");
	a_cfg_enable: assert property (@(posedge pclk) disable iff (!presetn)
		##1 filter_cfg[3].on == $past(filter_ctrl[31]))
		else $error("filter enable not decoded");
	a_cfg_mask: assert property (@(posedge pclk) disable iff (!presetn)
		##1 filter_cfg[2].mask_choice == $past(filter_ctrl[22:21]))
		else $error("mask choice misplaced");
	a_cfg_dest: assert property (@(posedge pclk) disable iff (!presetn)
		##1 filter_cfg[3].dest_queue == $past(filter_ctrl[28:24]))
		else $error("destination queue misplaced");
	a_byte_pack: assert property (@(posedge pclk) disable iff (!presetn)
		##1 filter_cfg[2].dest_queue == $past(filter_ctrl[20:16]))
		else $error("filter byte packing wrong");
	a_ovfl_sets: assert property (@(posedge pclk) disable iff (!presetn)
		!queue_is_transmit[0] && push[0] && full_v[0] |=> rx_ovfl[0])
		else $error("overflow not caught");
	a_ovfl_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		rx_ovfl[0] && !(wr && paddr == OFS_IRQ_CLEAR && pwdata[0]) |=> rx_ovfl[0])
		else $error("overflow flag dropped");
	a_full_level: assert property (@(posedge pclk) disable iff (!presetn)
		occ[0] <= DEPTH_C)
		else $error("occupancy beyond capacity");
	a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
		|(rx_ovfl & irq_en) |=> irq)
		else $error("interrupt missing");

	// flag word reads, checked for whichever queue the bus addresses
	a_dir_mask: assert property (@(posedge pclk) disable iff (!presetn)
		flag_rd && queue_is_transmit[qsel] |=> prdata[3:0] == 4'h0)
		else $error("receive flags shown on transmit queue");

	a_tx_empty: assert property (@(posedge pclk) disable iff (!presetn)
		flag_rd && queue_is_transmit[qsel] |=> prdata[8] == ($past(occ[qsel]) == '0))
		else $error("transmit empty flag wrong");

	a_tx_half: assert property (@(posedge pclk) disable iff (!presetn)
		flag_rd && queue_is_transmit[qsel] |=> prdata[9] == ($past(occ[qsel]) <= HALF_C))
		else $error("transmit half-empty flag wrong");

	a_rx_mask: assert property (@(posedge pclk) disable iff (!presetn)
		flag_rd && !queue_is_transmit[qsel] |=> prdata[9:8] == 2'b00)
		else $error("transmit flags shown on receive queue");

	a_rx_full: assert property (@(posedge pclk) disable iff (!presetn)
		flag_rd && !queue_is_transmit[qsel] |=> prdata[2] == $past(full_v[qsel]))
		else $error("receive full flag wrong");

	a_rx_ovfl_read: assert property (@(posedge pclk) disable iff (!presetn)
		flag_rd && !queue_is_transmit[qsel] |=> prdata[3] == $past(rx_ovfl[qsel]))
		else $error("receive overflow flag not shown");

	a_rx_nemp: assert property (@(posedge pclk) disable iff (!presetn)
		flag_rd && !queue_is_transmit[qsel] |=> prdata[0] == ($past(occ[qsel]) != '0) && prdata[1] == ($past(occ[qsel]) >= HALF_C))
		else $error("receive level flags wrong");

	a_flag_spare: assert property (@(posedge pclk) disable iff (!presetn)
		flag_rd |=> prdata[31:10] == 22'h0 && prdata[7:4] == 4'h0)
		else $error("spare flag bits not zero");

	// filter bytes: locking, open writes, decoding of the lower filters and of filter 3's mask choice
	a_lock_byte2: assert property (@(posedge pclk) disable iff (!presetn)
		filter_ctrl[23] && $past(filter_ctrl[23]) |-> filter_ctrl[22:16] == $past(filter_ctrl[22:16]))
		else $error("enabled filter settings changed");

	a_lock_byte1: assert property (@(posedge pclk) disable iff (!presetn)
		filter_ctrl[15] && $past(filter_ctrl[15]) |-> filter_ctrl[14:8] == $past(filter_ctrl[14:8]))
		else $error("enabled filter settings changed");

	a_lock_byte0: assert property (@(posedge pclk) disable iff (!presetn)
		filter_ctrl[7] && $past(filter_ctrl[7]) |-> filter_ctrl[6:0] == $past(filter_ctrl[6:0]))
		else $error("enabled filter settings changed");

	a_open_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == OFS_FILTER_CTRL && pstrb[3] && !filter_ctrl[31] |=> filter_ctrl[31:24] == $past(pwdata[31:24]))
		else $error("disabled filter ignored a write");

	a_cfg_low: assert property (@(posedge pclk) disable iff (!presetn)
		##1 filter_cfg[1:0] == $past(filter_ctrl[15:0]))
		else $error("lower filter bytes misplaced");

	a_cfg_mask3: assert property (@(posedge pclk) disable iff (!presetn)
		##1 filter_cfg[3].mask_choice == $past(filter_ctrl[30:29]))
		else $error("mask choice misplaced");

	a_cfg_on0: assert property (@(posedge pclk) disable iff (!presetn)
		##1 filter_cfg[0].on == $past(filter_ctrl[7]))
		else $error("filter enable not decoded");

	// a clear with no overflow in the same cycle drops the sticky bit
	a_ovfl_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == OFS_IRQ_CLEAR && pwdata[0] && !(push[0] && full_v[0] && !queue_is_transmit[0]) |=> !rx_ovfl[0])
		else $error("overflow flag not cleared");

	// bus answer and interrupt level
	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready longer than one cycle");

	a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("pslverr without pready");

	a_irq_drop: assert property (@(posedge pclk) disable iff (!presetn)
		!(|(rx_ovfl & irq_en)) |=> !irq)
		else $error("interrupt without enabled status");
endmodule : can_filter_fifo_status
`default_nettype wire

// File: tb/queue_traffic.sv
// partner model: turns one queue request into push or pop pulses
`timescale 1ns/100ps
`default_nettype none
module queue_traffic (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [4:0] q,
	input  wire logic       go_push,
	input  wire logic       go_pop,
	output logic [31:0]     push,
	output logic [31:0]     pop
);
	// one-cycle pulse on the addressed queue only, so no stray traffic elsewhere
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			push <= '0;
			pop  <= '0;
		end
		else
		begin
			push <= go_push ? 32'h1 << q : 32'h0;
			pop  <= go_pop ? 32'h1 << q : 32'h0;
		end
	end
endmodule : queue_traffic
`default_nettype wire

// File: tb/testbench.sv
// bench: register and queue model compared with the block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin err_total++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
	import can_filt_pkg::*;
	localparam int D = 8;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic              go_push, go_pop;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, push, pop, dir, qtx, r, flt, v;
	logic [3:0]        pstrb, sb;
	logic [4:0]        gq;
	bit [31:0]         ovf;
	filter_cfg_t [3:0] filter_cfg;
	int                err_total, cmp_count, cyc, occ[32], rq, tq;

	can_filter_fifo_status #(.DEPTH(D)) can_filter_fifo_status_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.push(push), .pop(pop), .filter_cfg(filter_cfg), .queue_is_transmit(qtx), .irq(irq));
	queue_traffic queue_traffic_inst (.pclk(pclk), .presetn(presetn), .q(gq),
		.go_push(go_push), .go_pop(go_pop), .push(push), .pop(pop));

	task automatic report_and_stop();
		if (err_total == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [31:0] exp_flags(input int q);
		logic [31:0] f;
		f = '0;
		if (dir[q])
		begin
			f[9] = occ[q] <= D / 2;
			f[8] = occ[q] == 0;
		end
		else
		begin
			f[3] = ovf[q];
			f[2] = occ[q] == D;
			f[1] = occ[q] >= D / 2;
			f[0] = occ[q] != 0;
		end
		return f;
	endfunction : exp_flags

	// push or pop one message, update the model, then read the queue's flags
	task automatic traffic(input int q, input logic p);
		@(posedge pclk);
		gq      <= 5'(q);
		go_push <= p;
		go_pop  <= !p;
		@(posedge pclk);
		go_push <= 1'b0;
		go_pop  <= 1'b0;
		repeat (2) @(posedge pclk);
		if (p && occ[q] < D) occ[q]++;
		else if (p && !dir[q]) ovf[q] = 1'b1;
		else if (!p && occ[q] > 0) occ[q]--;
		apb(1'b0, OFS_QUEUE_FLAGS + 12'(4 * q), 32'h0, 4'hf);
		`CHK(r, exp_flags(q))
	endtask : traffic

	// irq is a registered level: give it two edges after the cause
	task automatic irq_is(input logic x);
		repeat (2) @(posedge pclk);
		`CHK(irq, x)
	endtask : irq_is

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// hang guard well above the expected run length
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			report_and_stop();
		end
	end

	initial
	begin
		{presetn, psel, penable, pwrite, go_push, go_pop} = '0;
		{paddr, pwdata, pstrb, gq, dir, flt} = '0;
		void'($urandom(52));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_FILTER_CTRL, 32'h0, 4'hf);
		`CHK(r, RST_FILTER_CTRL)
		// random bytes and strobes: locked filters keep all but their enable
		repeat (16)
		begin
			v  = $urandom;
			sb = 4'($urandom);
			apb(1'b1, OFS_FILTER_CTRL, v, sb);
			for (int b = 0; b < 4; b++)
				if (sb[b] && flt[8*b+7]) flt[8*b+7] = v[8*b+7];
				else if (sb[b]) flt[8*b+:8] = v[8*b+:8];
			apb(1'b0, OFS_FILTER_CTRL, 32'h0, 4'hf);
			`CHK(r, flt)
			`CHK(32'(filter_cfg), flt)
		end
		rq  = $urandom % 32;
		tq  = rq ^ 1;
		dir = 32'h1 << tq;
		apb(1'b1, OFS_QUEUE_DIR, dir, 4'hf);
		apb(1'b0, OFS_QUEUE_DIR, 32'h0, 4'hf);
		`CHK(qtx, dir)
		apb(1'b1, OFS_IRQ_ENABLE, 32'h1 << rq, 4'hf);
		traffic(rq, 1'b0);
		repeat (D + 1) traffic(rq, 1'b1);
		irq_is(1'b1);
		repeat (D + 1) traffic(rq, 1'b0);
		apb(1'b0, OFS_IRQ_STATUS, 32'h0, 4'hf);
		`CHK(r, 32'h1 << rq)
		apb(1'b1, OFS_IRQ_ENABLE, 32'h0, 4'hf);
		irq_is(1'b0);
		apb(1'b1, OFS_IRQ_ENABLE, 32'h1 << rq, 4'hf);
		irq_is(1'b1);
		apb(1'b1, OFS_IRQ_CLEAR, 32'h1 << rq, 4'hf);
		ovf[rq] = 1'b0;
		irq_is(1'b0);
		traffic(rq, 1'b0);
		repeat (D + 1) traffic(tq, 1'b1);
		repeat (D + 1) traffic(tq, 1'b0);
		apb(1'b0, OFS_IRQ_STATUS, 32'h0, 4'hf);
		`CHK(r, 32'h0)
		apb(1'b0, 12'h040, 32'h0, 4'hf);
		`CHK({e, r}, {1'b1, UNMAPPED_DATA})
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
